// ---- inc/field_pair_changeover_ctrl_regs.svh ----
// field_pair_changeover_ctrl_regs.svh: register offsets, field positions, reset values, timing
// assumes a 125 MHz pclk and millisecond timing derived from it
`ifndef FIELD_PAIR_CHANGEOVER_CTRL_REGS_SVH
`define FIELD_PAIR_CHANGEOVER_CTRL_REGS_SVH

// register byte offsets
`define CTRL_OFFSET        12'h000
`define CHG_TIME_OFFSET    12'h004
`define STATUS_OFFSET      12'h008
`define MONITOR_OFFSET     12'h00c

// control register fields
`define CTRL_MODE_A_LSB    0
`define CTRL_MODE_B_LSB    2
`define CTRL_B_EN_BIT      4
`define CTRL_START_LSB     5

// reset values: fixed selection, second function off, start/restart interlock
`define CTRL_RESET         32'h0000_0040
`define CHG_TIME_RESET     32'h0028_0028

// status register fields
`define STAT_OUT_LSB       0
`define STAT_FAULT_LSB     2
`define STAT_LOCKED_BIT    4
`define STAT_CHG_LSB       5
`define STAT_PAIR_A_LSB    8
`define STAT_PAIR_B_LSB    12
`define MON_B_LSB          16

// timing
`define CLK_HZ             125000000
`define MS_PER_S           1000
`define MIN_CHG_MS         40
`define SYNC_MS            40
`define PRESS_MIN_MS       120
`define PRESS_MAX_MS       4000

`endif

// ---- inc/field_pair_pkg.sv ----
// field_pair_pkg: types of the field pair changeover controller
// assumes the register header supplies all numbers
package field_pair_pkg;

  typedef enum logic [1:0] {MODE_FIXED, MODE_OVERLAP, MODE_MOMENT} mode_type;

  typedef enum logic [1:0] {START_AUTO, START_INTERLOCK, START_RESTART_INTERLOCK} start_type;

  typedef enum logic {CHG_IDLE, CHG_WINDOW} chg_state_type;

  typedef struct packed {
    chg_state_type st;
    logic          established;
    logic          fault;
    logic [3:0]    pair;
    logic [4:0]    ref_sel;
    logic [4:0]    stab_sel;
    logic [15:0]   timer;
    logic [9:0]    mon;
    logic          out;
  } func_type;

  typedef struct packed {
    logic [2:0][4:0] sync_a;
    logic [2:0][4:0] sync_b;
    logic [2:0]      sync_btn;
    logic [1:0][4:0] sel;
    logic            btn;
    logic            btn_prev;
    logic [16:0]     ms_cnt;
    logic            tick;
    logic [31:0]     ctrl;
    logic [31:0]     chg_time;
    logic            locked;
    logic [12:0]     press_cnt;
    func_type [1:0]  fn;
    logic [31:0]     prdata;
    logic            pslverr;
  } state_type;

endpackage : field_pair_pkg

// ---- core/field_pair_changeover_ctrl.sv ----
// field_pair_changeover_ctrl: start/restart interlock and field pair selection/changeover
// assumes an APB master on pclk, select pins and reset button from outside, violation flags from scan logic
//
// Function
// - after power-up outputs stay off until reset button when start interlock set.
// - restart interlock keeps outputs off after field clears; implies start interlock.
// - once interlocked, only a reset button press or a write selecting auto start re-enables, never clearance alone.
// - ten selectable field pairs per function, changeable at any time.
// - any changeover violation raises fault and forces that function's safety output off.
// - three modes: fixed pair, overlapped monitoring, fixed changeover moment.
// - the previously active pair stays monitored during the changeover.
// - moment mode: occupied new field switches off within 40 ms+changeover+response.
// - overlapped mode: occupied new field switches off within 40 ms+response.
// - changeover time never below 40 ms; zero behaves as 40 ms.
// - fixed mode monitors first pair and ignores select inputs.
// - overlapped mode covers at most five pairs on five inputs.
// - overlapped mode: at most two pairs selected; a pair is active only while selected.
// - overlapped mode monitors both selected pairs throughout the window.
// - window starts on second selection; one pair must remain at expiry.
// - overlapped mode decodes five inputs one-hot, input n selects pair n.
// - second function decodes its own five inputs the same way.
// - moment mode starts timer on any input change; needs valid stable code at expiry.
// - moment mode monitors the new pair only after the window expires.
// - ten-pair decode: four high one low, pair six has fifth input low.
// - reset press valid only if held 0.12 s to 4 s.
`timescale 1ns/10ps
`include "field_pair_changeover_ctrl_regs.svh"

module field_pair_changeover_ctrl #(
  parameter int unsigned MS_CYCLES = `CLK_HZ / `MS_PER_S
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        select_in_1,
  input  wire logic        select_in_2,
  input  wire logic        select_in_3,
  input  wire logic        select_in_4,
  input  wire logic        select_in_5,
  input  wire logic [4:0]  second_function_select_inputs,
  input  wire logic        reset_button,
  input  wire logic [9:0]  field_violation_a,
  input  wire logic [9:0]  field_violation_b,
  output logic      [1:0]  safety_out,
  output logic      [1:0]  changeover_fault,
  output logic      [1:0]  changeover_active,
  output logic      [9:0]  monitored_a,
  output logic      [9:0]  monitored_b,
  output logic             interlocked
);

  ////////////////////////////////////////////////////////////////////////////
  // constants and helpers

  localparam logic [16:0] MS_LAST   = 17'(MS_CYCLES - 1);
  localparam logic [15:0] MIN_CHG   = 16'(`MIN_CHG_MS);
  localparam logic [12:0] PRESS_MIN = 13'(`PRESS_MIN_MS);
  localparam logic [12:0] PRESS_MAX = 13'(`PRESS_MAX_MS);

  // returns {valid, pair index}; pair index 0 is the first pair
  function automatic logic [4:0] decode_sel(input logic [4:0] s, input logic ten);
    logic [4:0] r;
    r = 5'h00;
    for (int k = 0; k < 5; k++)
    begin
      if (s == 5'(1 << k))
        r = {1'b1, 4'(k)};
      // single low input selects pairs six to ten
      else if (ten && (s == ~5'(1 << k)))
        r = {1'b1, 4'(9 - k)};
    end
    return r;
  endfunction : decode_sel

  function automatic logic [2:0] count_sel(input logic [4:0] s);
    logic [2:0] c;
    c = 3'h0;
    for (int k = 0; k < 5; k++)
      c = c + {2'h0, s[k]};
    return c;
  endfunction : count_sel

  ////////////////////////////////////////////////////////////////////////////
  // state

  field_pair_pkg::state_type state_q;
  field_pair_pkg::state_type state_d;

  always_comb
  begin
    field_pair_pkg::mode_type      mode;
    field_pair_pkg::start_type     start_mode;
    logic [4:0]                    sel;
    logic [4:0]                    dec;
    logic [4:0]                    cur_hot;
    logic [2:0]                    cnt;
    logic [15:0]                   cfg_t;
    logic [15:0]                   load;
    logic                          expire;
    logic                          en;
    logic                          valid_press;
    logic [1:0]                    viol;
    logic                          wr;
    logic                          setup;
    mode        = field_pair_pkg::MODE_FIXED;
    start_mode  = field_pair_pkg::start_type'(state_q.ctrl[`CTRL_START_LSB +: 2]);
    sel         = 5'h00;
    dec         = 5'h00;
    cur_hot     = 5'h00;
    cnt         = 3'h0;
    cfg_t       = 16'h0000;
    load        = 16'h0000;
    expire      = 1'b0;
    en          = 1'b0;
    valid_press = 1'b0;
    viol        = 2'b00;
    wr          = psel && penable && pwrite;
    setup       = psel && !penable;
    state_d     = state_q;

    //////////////////////////////////////////////////////////////////////////
    // pin synchronisers: a level counts once the second and third stages agree
    state_d.sync_a[0] = {select_in_5, select_in_4, select_in_3, select_in_2, select_in_1};
    state_d.sync_a[1] = state_q.sync_a[0];
    state_d.sync_a[2] = state_q.sync_a[1];
    state_d.sync_b[0] = second_function_select_inputs;
    state_d.sync_b[1] = state_q.sync_b[0];
    state_d.sync_b[2] = state_q.sync_b[1];
    state_d.sync_btn  = {state_q.sync_btn[1:0], reset_button};
    for (int i = 0; i < 5; i++)
    begin
      if (state_q.sync_a[1][i] == state_q.sync_a[2][i])
        state_d.sel[0][i] = state_q.sync_a[2][i];
      // second function uses its own inputs
      if (state_q.sync_b[1][i] == state_q.sync_b[2][i])
        state_d.sel[1][i] = state_q.sync_b[2][i];
    end
    if (state_q.sync_btn[1] == state_q.sync_btn[2])
      state_d.btn = state_q.sync_btn[2];
    state_d.btn_prev = state_q.btn;

    // millisecond tick from the clock divider
    if (state_q.ms_cnt == MS_LAST)
    begin
      state_d.ms_cnt = 17'h0_0000;
      state_d.tick   = 1'b1;
    end
    else
    begin
      state_d.ms_cnt = state_q.ms_cnt + 17'h0_0001;
      state_d.tick   = 1'b0;
    end

    //////////////////////////////////////////////////////////////////////////
    // APB slave: read data captured in setup, writes land in the access cycle
    if (setup)
    begin
      state_d.pslverr = 1'b0;
      state_d.prdata  = 32'h0000_0000;
      case (paddr)
        `CTRL_OFFSET:     state_d.prdata = {25'h000_0000, state_q.ctrl[6:0]};
        `CHG_TIME_OFFSET: state_d.prdata = state_q.chg_time;
        `STATUS_OFFSET:
        begin
          state_d.prdata[`STAT_OUT_LSB +: 2]    = {state_q.fn[1].out, state_q.fn[0].out};
          state_d.prdata[`STAT_FAULT_LSB +: 2]  = {state_q.fn[1].fault, state_q.fn[0].fault};
          state_d.prdata[`STAT_LOCKED_BIT]      = state_q.locked;
          state_d.prdata[`STAT_CHG_LSB +: 2]    = {state_q.fn[1].st == field_pair_pkg::CHG_WINDOW,
                                                   state_q.fn[0].st == field_pair_pkg::CHG_WINDOW};
          state_d.prdata[`STAT_PAIR_A_LSB +: 4] = state_q.fn[0].pair;
          state_d.prdata[`STAT_PAIR_B_LSB +: 4] = state_q.fn[1].pair;
        end
        `MONITOR_OFFSET:
        begin
          state_d.prdata[9:0]              = state_q.fn[0].mon;
          state_d.prdata[`MON_B_LSB +: 10] = state_q.fn[1].mon;
        end
        default:          state_d.pslverr = 1'b1;
      endcase
    end
    if (wr && (paddr == `CTRL_OFFSET))
      state_d.ctrl = {25'h000_0000, pwdata[6:0]};
    if (wr && (paddr == `CHG_TIME_OFFSET))
      state_d.chg_time = pwdata;

    //////////////////////////////////////////////////////////////////////////
    // reset button: measure hold time in ms, judge at release
    if (state_q.btn && state_q.tick && (state_q.press_cnt <= PRESS_MAX))
      state_d.press_cnt = state_q.press_cnt + 13'h0001;
    if (!state_q.btn && state_q.btn_prev)
    begin
      state_d.press_cnt = 13'h0000;
      // hold window 0.12 s to 4 s
      valid_press = (state_q.press_cnt >= PRESS_MIN) && (state_q.press_cnt <= PRESS_MAX);
    end
    if (!state_q.btn)
      state_d.press_cnt = 13'h0000;

    //////////////////////////////////////////////////////////////////////////
    // ten pairs per function, changeover at any time
    for (int f = 0; f < 2; f++)
    begin
      en      = (f == 0) || state_q.ctrl[`CTRL_B_EN_BIT];
      mode    = field_pair_pkg::mode_type'(state_q.ctrl[f * 2 +: 2]);
      sel     = state_q.sel[f];
      cnt     = count_sel(sel);
      cfg_t   = state_q.chg_time[f * 16 +: 16];
      // zero or short setting acts as 40 ms
      // load max of setting and minimum
      load    = (cfg_t < MIN_CHG) ? MIN_CHG : cfg_t;
      expire  = state_q.tick && (state_q.fn[f].timer == 16'h0001);
      cur_hot = 5'(1 << state_q.fn[f].pair[2:0]);
      viol[f] = en && |(field_violation_a & {10{f == 0}} & state_q.fn[f].mon
                      | field_violation_b & {10{f == 1}} & state_q.fn[f].mon);
      if (state_q.fn[f].st == field_pair_pkg::CHG_WINDOW && state_q.tick)
        state_d.fn[f].timer = state_q.fn[f].timer - 16'h0001;
      if (state_q.tick)
        state_d.fn[f].stab_sel = sel;

      case (mode)
        field_pair_pkg::MODE_OVERLAP:
        begin
          // only the five one-hot pairs exist in this mode
          dec = decode_sel(sel, 1'b0);
          if (!state_q.fn[f].established)
          begin
            if (dec[4])
            begin
              state_d.fn[f].pair        = dec[3:0];
              state_d.fn[f].established = !state_q.fn[f].fault;
            end
          end
          else if (state_q.fn[f].st == field_pair_pkg::CHG_IDLE)
          begin
            if (cnt == 3'h2 && (sel & cur_hot) != 5'h00)
            begin
              state_d.fn[f].st    = field_pair_pkg::CHG_WINDOW;
              state_d.fn[f].timer = load;
            end
            // dropping or swapping without overlap is a violation
            else if (sel != cur_hot)
              state_d.fn[f].fault = 1'b1;
          end
          else
          begin
            // more than two, none, or a foreign pair
            if (cnt == 3'h0 || cnt > 3'h2 || (cnt == 3'h2 && (sel & cur_hot) == 5'h00))
              state_d.fn[f].fault = 1'b1;
            else if (cnt == 3'h1)
            begin
              state_d.fn[f].st   = field_pair_pkg::CHG_IDLE;
              state_d.fn[f].pair = dec[3:0];
            end
            else if (expire)
              state_d.fn[f].fault = 1'b1;
          end
          // a pair is monitored only while selected
          // both selected pairs monitored in the window
          state_d.fn[f].mon = state_q.fn[f].established ? {5'h00, sel} : 10'h000;
        end
        field_pair_pkg::MODE_MOMENT:
        begin
          dec = decode_sel(sel, 1'b1);
          if (!state_q.fn[f].established)
          begin
            if (dec[4])
            begin
              state_d.fn[f].pair        = dec[3:0];
              state_d.fn[f].ref_sel     = sel;
              state_d.fn[f].established = !state_q.fn[f].fault;
            end
          end
          // any registered change starts the timer
          else if (state_q.fn[f].st == field_pair_pkg::CHG_IDLE)
          begin
            if (sel != state_q.fn[f].ref_sel)
            begin
              state_d.fn[f].st    = field_pair_pkg::CHG_WINDOW;
              state_d.fn[f].timer = load;
            end
          end
          else if (expire)
          begin
            state_d.fn[f].st = field_pair_pkg::CHG_IDLE;
            // invalid or unsettled code at window close
            if (dec[4] && sel == state_q.fn[f].stab_sel)
            begin
              // new pair monitored only from expiry on
              state_d.fn[f].pair    = dec[3:0];
              state_d.fn[f].ref_sel = sel;
            end
            else
              state_d.fn[f].fault = 1'b1;
          end
          // old pair stays monitored through the window
          state_d.fn[f].mon = state_q.fn[f].established ? 10'(1 << state_q.fn[f].pair) : 10'h000;
        end
        default:
        begin
          state_d.fn[f].pair        = 4'h0;
          state_d.fn[f].st          = field_pair_pkg::CHG_IDLE;
          state_d.fn[f].established = 1'b1;
          state_d.fn[f].mon         = 10'h001;
        end
      endcase

      // a fault drops the pair and the window
      if (state_d.fn[f].fault)
      begin
        state_d.fn[f].established = 1'b0;
        state_d.fn[f].st          = field_pair_pkg::CHG_IDLE;
      end
      if (!en)
      begin
        state_d.fn[f].fault       = 1'b0;
        state_d.fn[f].established = 1'b0;
        state_d.fn[f].st          = field_pair_pkg::CHG_IDLE;
        state_d.fn[f].mon         = 10'h000;
      end
    end

    //////////////////////////////////////////////////////////////////////////
    // start/restart interlock; one shared lock for both functions
    // violation relocks under restart interlock
    if (start_mode == field_pair_pkg::START_RESTART_INTERLOCK && viol != 2'b00)
      state_d.locked = 1'b1;
    // a valid press with clear fields unlocks; auto start mode also clears the lock
    else if (valid_press && viol == 2'b00)
      state_d.locked = 1'b0;
    if (start_mode == field_pair_pkg::START_AUTO)
      state_d.locked = 1'b0;
    // a valid press acknowledges older faults; one raised in this very cycle wins
    if (valid_press && viol == 2'b00)
      for (int f = 0; f < 2; f++)
        state_d.fn[f].fault = state_d.fn[f].fault && !state_q.fn[f].fault;

    // occupied field seen once monitored, outputs drop within a cycle
    // overlap monitors the new pair at once, so no extra delay
    // faults and the lock force outputs off
    for (int f = 0; f < 2; f++)
      state_d.fn[f].out = (f == 0 || state_q.ctrl[`CTRL_B_EN_BIT]) && !state_q.locked && !viol[f]
                          && !state_q.fn[f].fault && state_q.fn[f].established;
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q          <= '0;
      state_q.ctrl     <= `CTRL_RESET;
      state_q.chg_time <= `CHG_TIME_RESET;
      // locked from power-up until a valid press or a write selecting auto start
      state_q.locked   <= 1'b1;
    end
    else
      state_q <= state_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  // zero wait states: read data was captured in the setup cycle
  assign pready            = 1'b1;
  assign prdata            = state_q.prdata;
  assign pslverr           = state_q.pslverr && psel && penable;
  assign safety_out        = {state_q.fn[1].out, state_q.fn[0].out};
  assign changeover_fault  = {state_q.fn[1].fault, state_q.fn[0].fault};
  assign changeover_active = {state_q.fn[1].st == field_pair_pkg::CHG_WINDOW,
                              state_q.fn[0].st == field_pair_pkg::CHG_WINDOW};
  assign monitored_a       = state_q.fn[0].mon;
  assign monitored_b       = state_q.fn[1].mon;
  assign interlocked       = state_q.locked;

endmodule : field_pair_changeover_ctrl

// ---- bench/select_ctrl_model.sv ----
// select_ctrl_model: external safety control driving five select pins
// assumes go is a one-cycle pulse from the bench, target is the new pin pattern
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////
module select_ctrl_model (
  input  wire logic        pclk,
  input  wire logic        go,
  input  wire logic        overlap,
  input  wire logic [4:0]  target,
  input  wire logic [15:0] hold,
  output logic      [4:0]  sel
);
  initial sel = 5'h00;
  // with overlap add new pair, drop old after hold; without it switch at once
  always @(posedge pclk)
    if (go)
    begin
      if (overlap)
      begin
        sel <= sel | target;
        repeat (hold) @(posedge pclk);
      end
      sel <= target;
    end
endmodule : select_ctrl_model

// ---- bench/field_pair_chk.sv ----
// field_pair_chk: port assertions of the changeover controller
// assumes binding into field_pair_changeover_ctrl, one pclk domain
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////
module field_pair_chk #(
  parameter int unsigned MS_CYCLES = 10
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        reset_button,
  input wire logic [9:0]  field_violation_a,
  input wire logic [1:0]  safety_out,
  input wire logic [1:0]  changeover_fault,
  input wire logic [1:0]  changeover_active,
  input wire logic [9:0]  monitored_a,
  input wire logic [9:0]  monitored_b,
  input wire logic        interlocked
);
  logic [31:0] held_q;
  logic [31:0] last_q;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // press judged on release, so keep the length of the last one
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      held_q <= 32'h0000_0000;
      last_q <= 32'h0000_0000;
    end
    else if (reset_button)
      held_q <= held_q + 32'h0000_0001;
    else if (held_q != 32'h0000_0000)
    begin
      last_q <= held_q;
      held_q <= 32'h0000_0000;
    end
  ////////////////////////////////////////////////////////////////
  out_rise_unlocked_a: assert property (
    $rose(safety_out[0]) |-> !interlocked && !changeover_fault[0]) else $error("output enabled while locked");
  fault_holds_off_a: assert property (
    (changeover_fault & $past(changeover_fault) & safety_out) == 2'b00) else $error("output on during fault");
  old_pair_kept_a: assert property (
    $rose(changeover_active[0]) |=> (monitored_a & $past(monitored_a)) == $past(monitored_a))
    else $error("old pair dropped at window start");
  two_pairs_max_a: assert property (
    $countones(monitored_a) <= 2 && $countones(monitored_b) <= 2) else $error("more than two pairs");
  press_length_a: assert property (
    $fell(interlocked) |-> last_q >= 119 * MS_CYCLES && last_q <= 4001 * MS_CYCLES) else $error("bad press accepted");
  fault_clear_press_a: assert property (
    $fell(changeover_fault[0]) |-> !interlocked) else $error("fault cleared without press");
  violation_drop_a: assert property (
    |(field_violation_a & monitored_a) |-> ##[1:3] !safety_out[0]) else $error("violation kept output on");
  single_pair_idle_a: assert property (
    !changeover_active[0] && !$past(changeover_active[0]) && !changeover_fault[0] && monitored_a != 10'h000
    |-> $onehot(monitored_a)) else $error("several pairs outside window");
  cover property ($rose(changeover_active[0]));
  cover property ($fell(interlocked));
  cover property ($rose(changeover_fault[1]));
endmodule : field_pair_chk

bind field_pair_changeover_ctrl field_pair_chk #(.MS_CYCLES(MS_CYCLES)) u_chk (
  .pclk(pclk), .presetn(presetn), .reset_button(reset_button), .field_violation_a(field_violation_a),
  .safety_out(safety_out), .changeover_fault(changeover_fault), .changeover_active(changeover_active),
  .monitored_a(monitored_a), .monitored_b(monitored_b), .interlocked(interlocked));

// ---- bench/tb_top.sv ----
// tb_top: self-checking bench of the changeover controller
// assumes a millisecond of 10 clocks and two select control models
`timescale 1ns/10ps
module tb_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, reset_button, go_a, go_b, ovl;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [4:0]  sel_a, sel_b, tgt;
  logic [15:0] hold;
  logic [9:0]  fv_a, fv_b, monitored_a, monitored_b, prev;
  logic [1:0]  safety_out, changeover_fault, changeover_active;
  logic        interlocked;
  integer      seed;
  int          n_mismatch, compares, k, n;
  int          codes[10] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h0f, 5'h17, 5'h1b, 5'h1d, 5'h1e};
  ////////////////////////////////////////////////////////////////
  field_pair_changeover_ctrl #(.MS_CYCLES(10)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .select_in_1(sel_a[0]), .select_in_2(sel_a[1]), .select_in_3(sel_a[2]),
    .select_in_4(sel_a[3]), .select_in_5(sel_a[4]), .second_function_select_inputs(sel_b),
    .reset_button(reset_button), .field_violation_a(fv_a), .field_violation_b(fv_b),
    .safety_out(safety_out), .changeover_fault(changeover_fault), .changeover_active(changeover_active),
    .monitored_a(monitored_a), .monitored_b(monitored_b), .interlocked(interlocked));
  select_ctrl_model u_ctl_a (.pclk(pclk), .go(go_a), .overlap(ovl), .target(tgt), .hold(hold), .sel(sel_a));
  select_ctrl_model u_ctl_b (.pclk(pclk), .go(go_b), .overlap(ovl), .target(tgt), .hold(hold), .sel(sel_b));
  always #4 pclk = ~pclk;
  ////////////////////////////////////////////////////////////////
  task automatic summarize;
    $display("counts: compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic wait_ms(input int ms);
    repeat (ms * 10) @(posedge pclk);
  endtask : wait_ms
  // one transfer, then an idle cycle so psel is never set twice in a step
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int i;
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge pclk);
      i++;
    end
    while (pready !== 1'b1 && i < 50);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (i >= 50)
    begin
      n_mismatch++;
      summarize();
    end
    @(posedge pclk);
  endtask : apb
  task automatic drive(input logic b, input logic o, input logic [4:0] t, input int h);
    tgt  <= t;
    ovl  <= o;
    hold <= 16'(h);
    go_a <= !b;
    go_b <= b;
    @(posedge pclk);
    go_a <= 1'b0;
    go_b <= 1'b0;
  endtask : drive
  task automatic press(input int ms);
    reset_button <= 1'b1;
    wait_ms(ms);
    reset_button <= 1'b0;
    wait_ms(3);
  endtask : press
  ////////////////////////////////////////////////////////////////
  initial
  begin
    {pclk, presetn, psel, penable, pwrite, reset_button, go_a, go_b, ovl} = '0;
    {paddr, pwdata, tgt, hold, fv_a, fv_b} = '0;
    {n_mismatch, compares} = '0;
    seed = 32'h5615;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check(32'(interlocked), 32'h1);
    check(32'(safety_out), 32'h0);
    apb(1'b0, 12'h000, 32'h0);
    check(rd, 32'h0000_0040);
    apb(1'b0, 12'h004, 32'h0);
    check(rd, 32'h0028_0028);
    apb(1'b0, 12'h010, 32'h0);
    check(32'(err), 32'h1);
    for (k = 0; k < 4; k++)
    begin
      drive(1'b0, 1'b0, 5'($random(seed)), 0);
      wait_ms(1);
      check(32'(monitored_a), 32'h1);
    end
    press(50);
    check(32'(interlocked), 32'h1);
    press(150);
    check(32'(interlocked), 32'h0);
    check(32'(safety_out), 32'h1);
    fv_a <= 10'h002 << ($unsigned($random(seed)) % 9);
    wait_ms(1);
    check(32'(safety_out[0]), 32'h1);
    fv_a <= 10'h001;
    wait_ms(1);
    check(32'(safety_out[0]), 32'h0);
    fv_a <= 10'h000;
    wait_ms(2);
    check(32'(safety_out[0]), 32'h0);
    press(150);
    check(32'(safety_out[0]), 32'h1);
    $display("test interlock done");
    drive(1'b0, 1'b0, 5'h01, 0);
    // pins settle first, a stale random code would fault the new mode
    wait_ms(1);
    apb(1'b1, 12'h000, 32'h0000_0041);
    apb(1'b1, 12'h004, 32'h0028_0000);
    wait_ms(2);
    check(32'(monitored_a), 32'h1);
    drive(1'b0, 1'b1, 5'h04, 200);
    wait_ms(10);
    check(32'(changeover_active[0]), 32'h1);
    check(32'(monitored_a), 32'h5);
    wait_ms(20);
    check(32'(monitored_a), 32'h4);
    check(32'(changeover_fault[0]), 32'h0);
    $display("test overlap done");
    apb(1'b1, 12'h004, 32'h0000_0032);
    apb(1'b1, 12'h000, 32'h0000_0042);
    prev = 10'h004;
    for (k = 0; k < 10; k++)
    begin
      drive(1'b0, 1'b0, 5'(codes[k]), 0);
      wait_ms(25);
      check(32'(monitored_a), 32'(prev));
      check(32'(changeover_active[0]), 32'h1);
      wait_ms(35);
      prev = 10'h001 << k;
      check(32'(monitored_a), 32'(prev));
      check(32'(changeover_fault[0]), 32'h0);
    end
    drive(1'b0, 1'b0, 5'h03, 0);
    wait_ms(60);
    check(32'(changeover_fault[0]), 32'h1);
    check(32'(safety_out[0]), 32'h0);
    apb(1'b0, 12'h008, 32'h0);
    check(rd, 32'h0000_0904);
    $display("test moment done");
    n = $unsigned($random(seed)) % 5;
    drive(1'b1, 1'b0, 5'h01 << n, 0);
    apb(1'b1, 12'h000, 32'h0000_0056);
    wait_ms(2);
    check(32'(monitored_b), 32'h1 << n);
    drive(1'b1, 1'b1, 5'h01 << ((n + 1) % 5), 300);
    wait_ms(40);
    check(32'(changeover_fault[1]), 32'h0);
    check(32'(monitored_b), 32'h1 << ((n + 1) % 5));
    drive(1'b1, 1'b1, 5'h01 << n, 600);
    wait_ms(55);
    check(32'(changeover_fault[1]), 32'h1);
    check(32'(safety_out[1]), 32'h0);
    drive(1'b0, 1'b0, 5'h01, 0);
    wait_ms(60);
    press(150);
    check(32'(changeover_fault[0]), 32'h0);
    check(32'(interlocked), 32'h0);
    check(32'(safety_out[1]), 32'h1);
    fv_b <= monitored_b;
    wait_ms(1);
    check(32'(safety_out[1]), 32'h0);
    check(32'(interlocked), 32'h1);
    apb(1'b1, 12'h000, 32'h0000_0016);
    fv_b <= 10'h000;
    wait_ms(1);
    check(32'(safety_out[1]), 32'h1);
    $display("test second function done");
    summarize();
  end
endmodule : tb_top
